//--- pkg/thread_exc_pkg.sv
// holds constants, register map and carrier types of the thread exception unit
// assumes one hardware thread, apb register access and a same-clock issue pipeline
package thread_exc_pkg;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] off_thread_control = 8'h00;
	localparam logic [7:0] off_exception_enable_status = 8'h04;
	localparam logic [7:0] off_return_pointer = 8'h08;
	localparam logic [7:0] off_entry_pointer_lo = 8'h0C;
	localparam logic [7:0] off_entry_pointer_hi = 8'h10;
	localparam logic [7:0] off_thread_ip = 8'h14;
	localparam logic [7:0] off_reserved_slot = 8'h18;
	localparam logic [7:0] off_thread_identity = 8'h1C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ctrl_master_bit = 0;
	localparam int ctrl_scalar_bit = 1;
	localparam int exc_types = 8;
	localparam int exc_enable_lsb = 0;
	localparam int exc_status_lsb = 8;
	localparam int entry_width = 48;
	localparam int entry_hi_width = 16;
	localparam int ident_thread_lsb = 0;
	localparam int ident_unit_lsb = 8;

	// ----------------------------------------
	// reset values and sizes
	// ----------------------------------------
	localparam logic [31:0] ip_reset = 32'h0000_0000;
	localparam logic [31:0] ip_step = 32'h0000_0010;
	localparam logic [31:0] ip_align_mask = 32'hFFFF_FFF0;
	localparam logic [7:0] exc_enable_reset = 8'h00;
	localparam int grf_regs = 128;
	localparam int grf_index_width = 7;
	localparam int threads_per_unit = 4;
	localparam int unit_count = 8;
	localparam logic [7:0] hw_thread_index_default = 8'h00; // arbitrary
	localparam logic [7:0] exec_unit_index_default = 8'h00; // arbitrary

	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [grf_index_width-1:0] dst;
		logic [grf_index_width-1:0] src;
		logic keep_dependency_option;
		logic skip_dependency_check_option;
		logic cond_push;
		logic cond_pop;
	} instr_t;

	typedef struct packed {
		logic valid;
		logic [grf_index_width-1:0] dst;
		logic keep_dependency_option;
	} writeback_t;

	typedef enum logic [3:0] {
		st_app = 4'b0001,
		st_enter = 4'b0010,
		st_handler = 4'b0100,
		st_return = 4'b1000
	} thread_state_t;

endpackage

//--- rtl/thread_exception_entry_return.sv
// holds the per-thread exception entry and return logic with its apb registers
// assumes issue requests, writebacks and exception events come from logic on pclk
module thread_exception_entry_return #(
	parameter logic [7:0] hw_thread_index = thread_exc_pkg::hw_thread_index_default,
	parameter logic [7:0] exec_unit_index = thread_exc_pkg::exec_unit_index_default
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [thread_exc_pkg::exc_types-1:0] exc_raise,
	input wire logic instr_valid,
	input wire thread_exc_pkg::instr_t instr,
	output logic instr_ack,
	output logic [31:0] thread_ip,
	output logic handler_active,
	output logic mask_push,
	output logic mask_pop,
	input wire thread_exc_pkg::writeback_t wb
);
	import thread_exc_pkg::*;

	// ----------------------------------------
	// timing overview
	// ----------------------------------------
	// map: control at 0x00, enable and status at 0x04, return pointer at 0x08
	// entry pointer low word at 0x0C, its upper sixteen bits at 0x10
	// thread pointer view at 0x14, reserved handler slot at 0x18, identity at 0x1C
	// control: bit 0 master, set by entry only; bit 1 scalar branching
	// status word: enables in bits 7:0, latched events in bits 15:8
	// identity: thread index in bits 7:0, unit index in bits 15:8

	// apb: setup at edge e, ready and read data in the next cycle, write lands at e+1
	// every apb transfer has exactly one access cycle, no wait states
	// unmapped or misaligned addresses answer with an error and read zero
	// writes to the pointer and identity views are dropped without error
	// event: latched at edge e when its type is enabled, repeats of a latched type are lost
	// e+1: application issue stops, thread sits in the enter state for one cycle
	// e+2: return pointer saved, pointer set to the aligned entry, master bit set
	// handler: instructions issue as before, new events only latch
	// exit: software clears the master bit at edge w
	// w+1: return state, handler flag low
	// w+2: pointer restored; a still-pending enabled event starts a new entry at once
	// issue: taken when valid, no hazard, no ack standing and the state allows it
	// an accepted instruction answers with a one-cycle ack and a pointer step of sixteen
	// so at most one issue is taken every second cycle
	// scoreboard: issue sets the destination bit unless the check is skipped
	// a writeback clears it unless the keep option rides with it
	// a set and a clear of one bit in one cycle leave it set
	// a kept dependency is never cleared here, the stall it causes is intended
	// hazard: source or destination bit set blocks the issue, in handler or application
	// mask strobes follow the issue only while scalar branching is off

	// limitations
	// only one thread is modelled; the entry pointer is shared state written by software
	// entry pointer bits above 31 are stored and read back but never reach the thread pointer
	// a hung handler is not detected; only software or a context timeout recovers it
	// the thread pointer wraps silently at the top of the 32-bit range
	// flags, masks and accumulators outside this block are never saved or restored here

	// ----------------------------------------
	// state
	// ----------------------------------------
	thread_state_t state, next_state;
	logic ctrl_master, next_ctrl_master;
	logic scalar_branch_flag, next_scalar_branch_flag;
	logic [exc_types-1:0] exc_enable, next_exc_enable;
	logic [exc_types-1:0] exc_status, next_exc_status;
	logic [31:0] saved_return_pointer, next_saved_return_pointer;
	logic [entry_width-1:0] handler_entry_pointer, next_handler_entry_pointer;
	logic [31:0] handler_reserved_slot, next_handler_reserved_slot;
	logic [grf_regs-1:0] dep, next_dep;
	// next values of the thread outputs
	logic [31:0] next_thread_ip;
	logic next_instr_ack, next_handler_active, next_mask_push, next_mask_pop;
	// next values of the apb answer
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// decoded strobes and views
	logic bus_write, mapped, pending, hazard, can_issue;
	logic [31:0] entry_target, rd_value;
	logic [31:0] thread_control_word, exception_enable_status_word, thread_identity_word;

	// access edge of an apb transfer, the only edge at which a write lands
	assign bus_write = psel & penable & pready & pwrite & mapped;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
	// an enabled latched status bit asks for the handler
	assign pending = |(exc_status & exc_enable);
	// handler uses bits 31:4 of the entry pointer, low nibble forced zero
	assign entry_target = handler_entry_pointer[31:0] & ip_align_mask;
	// source or destination still waiting on a writeback, unless checks are skipped
	assign hazard = ~instr.skip_dependency_check_option & (dep[instr.src] | dep[instr.dst]);
	// no issue while the previous ack stands, nor while a handler is owed
	assign can_issue = instr_valid & ~instr_ack & ~hazard &
		((state == st_app & ~pending) | (state == st_handler));

	// read views of the architecture words
	always_comb begin
		thread_control_word = 32'h0000_0000;
		thread_control_word[ctrl_master_bit] = ctrl_master;
		thread_control_word[ctrl_scalar_bit] = scalar_branch_flag;
		exception_enable_status_word = 32'h0000_0000;
		exception_enable_status_word[exc_enable_lsb +: exc_types] = exc_enable;
		exception_enable_status_word[exc_status_lsb +: exc_types] = exc_status;
		thread_identity_word = 32'h0000_0000;
		// identity feeds the per-thread scratch offset computed by handler code
		thread_identity_word[ident_thread_lsb +: 8] = hw_thread_index;
		thread_identity_word[ident_unit_lsb +: 8] = exec_unit_index;
	end

	// read multiplexer
	always_comb begin
		rd_value = 32'h0000_0000;
		case (paddr)
			off_thread_control: rd_value = thread_control_word;
			off_exception_enable_status: rd_value = exception_enable_status_word;
			off_return_pointer: rd_value = saved_return_pointer;
			off_entry_pointer_lo: rd_value = handler_entry_pointer[31:0];
			off_entry_pointer_hi: rd_value = {16'h0000, handler_entry_pointer[entry_width-1:32]};
			off_thread_ip: rd_value = thread_ip;
			off_reserved_slot: rd_value = handler_reserved_slot;
			off_thread_identity: rd_value = thread_identity_word;
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// apb response
	// ----------------------------------------
	// ready rises in the access cycle, so every transfer has no wait state
	always_comb begin
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~mapped;
		next_prdata = prdata;
		// read data is captured at setup and stands for the access cycle
		if (psel & ~penable) begin
			next_prdata = mapped ? rd_value : 32'h0000_0000;
		end
	end

	// apb answer registers, cleared by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------
	// thread sequencing and registers
	// ----------------------------------------
	always_comb begin
		// hold every value except the ack and mask strobes, which default low, unless a branch below changes it
		next_state = state;
		next_ctrl_master = ctrl_master;
		next_scalar_branch_flag = scalar_branch_flag;
		next_exc_enable = exc_enable;
		next_exc_status = exc_status;
		next_saved_return_pointer = saved_return_pointer;
		next_handler_entry_pointer = handler_entry_pointer;
		next_handler_reserved_slot = handler_reserved_slot;
		next_dep = dep;
		next_thread_ip = thread_ip;
		next_instr_ack = 1'b0;
		next_mask_push = 1'b0;
		next_mask_pop = 1'b0;

		// software writes
		if (bus_write) begin
			case (paddr)
				off_thread_control: begin
					// only a clear of the master bit is honoured, hardware alone sets it
					if (!pwdata[ctrl_master_bit]) begin
						next_ctrl_master = 1'b0;
					end
					next_scalar_branch_flag = pwdata[ctrl_scalar_bit];
				end
				off_exception_enable_status: begin
					next_exc_enable = pwdata[exc_enable_lsb +: exc_types];
					next_exc_status = pwdata[exc_status_lsb +: exc_types];
				end
				off_return_pointer: next_saved_return_pointer = pwdata;
				// entry-set command path, low word then high half
				off_entry_pointer_lo: next_handler_entry_pointer[31:0] = pwdata;
				off_entry_pointer_hi: begin
					next_handler_entry_pointer[entry_width-1:32] = pwdata[entry_hi_width-1:0];
				end
				// reserved 32-bit slot, the only storage kept for the handler
				off_reserved_slot: next_handler_reserved_slot = pwdata;
				default: next_state = state;
			endcase
		end

		// new events latch once per type; a set beats a clear in the same cycle
		next_exc_status = next_exc_status | (exc_raise & exc_enable);

		// dependency scoreboard: writeback clears unless kept
		if (wb.valid && !wb.keep_dependency_option) begin
			next_dep[wb.dst] = 1'b0;
		end

		// instruction issue
		if (can_issue) begin
			next_instr_ack = 1'b1;
			next_thread_ip = thread_ip + ip_step;
			// first instruction of a block sets the dependency, interior ones skip it
			if (!instr.skip_dependency_check_option) begin
				next_dep[instr.dst] = 1'b1;
			end
			// scalar branching leaves the hardware mask stacks untouched
			next_mask_push = instr.cond_push & ~scalar_branch_flag;
			next_mask_pop = instr.cond_pop & ~scalar_branch_flag;
		end

		// flags and mask stacks are left as they are on entry and exit
		case (state)
			st_app: begin
				// an owed handler wins over any further application issue
				if (pending) begin
					next_state = st_enter;
				end
			end
			st_enter: begin
				// current pointer saved, then common entry pointer loaded
				next_saved_return_pointer = thread_ip;
				next_thread_ip = entry_target;
				next_ctrl_master = 1'b1;
				next_state = st_handler;
			end
			st_handler: begin
				// further events only latch here, they never nest an entry
				if (!ctrl_master) begin
					next_state = st_return;
				end
			end
			st_return: begin
				next_thread_ip = saved_return_pointer;
				// a status bit left set, e.g. single step, simply enters again
				if (pending) begin
					next_state = st_enter;
				end else begin
					next_state = st_app;
				end
			end
			default: next_state = st_app;
		endcase
		// handler flag mirrors the state the thread moves to
		next_handler_active = (next_state == st_handler);
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	// every output is a flop, reset puts the thread in application state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_app;
			ctrl_master <= 1'b0;
			scalar_branch_flag <= 1'b0;
			exc_enable <= exc_enable_reset;
			exc_status <= 8'h00;
			saved_return_pointer <= ip_reset;
			handler_entry_pointer <= 48'h0000_0000_0000;
			handler_reserved_slot <= 32'h0000_0000;
			dep <= '0;
			thread_ip <= ip_reset;
			instr_ack <= 1'b0;
			handler_active <= 1'b0;
			mask_push <= 1'b0;
			mask_pop <= 1'b0;
		end else begin
			state <= next_state;
			ctrl_master <= next_ctrl_master;
			scalar_branch_flag <= next_scalar_branch_flag;
			exc_enable <= next_exc_enable;
			exc_status <= next_exc_status;
			saved_return_pointer <= next_saved_return_pointer;
			handler_entry_pointer <= next_handler_entry_pointer;
			handler_reserved_slot <= next_handler_reserved_slot;
			dep <= next_dep;
			thread_ip <= next_thread_ip;
			instr_ack <= next_instr_ack;
			handler_active <= next_handler_active;
			mask_push <= next_mask_push;
			mask_pop <= next_mask_pop;
		end
	end

endmodule

//--- bench/thread_exc_chk.sv
// holds the port checker of the thread exception unit
// assumes bind to the top module, one clock domain
module thread_exc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic instr_valid,
	input wire logic instr_ack,
	input wire logic [31:0] thread_ip,
	input wire logic handler_active,
	input wire logic mask_push,
	input wire logic mask_pop
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	chk_apb_answer: assert property (setup_s |=> access_s) else $error("no answer after setup");
	chk_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
	chk_bad_addr: assert property (pready && (paddr >= 8'h20 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	// ----------------------------------------
	// issue and pointer
	// ----------------------------------------
	chk_ack_pulse: assert property (instr_ack |=> !instr_ack) else $error("ack wider than a cycle");
	chk_ack_cause: assert property (instr_ack |-> $past(instr_valid)) else $error("ack without request");
	chk_ip_step: assert property (instr_ack |-> thread_ip == $past(thread_ip) + 32'h10) else $error("ip step wrong");
	// no issue, no entry, and not the cycle after a return that restores the pointer
	sequence ip_quiet_s;
		!instr_ack && $stable(handler_active) && $past(handler_active) == $past(handler_active, 2);
	endsequence
	chk_ip_hold: assert property (ip_quiet_s |-> $stable(thread_ip))
		else $error("ip moved without cause");
	chk_entry_align: assert property ($rose(handler_active) |-> thread_ip[3:0] == 4'h0)
		else $error("entry ip not aligned");
	chk_entry_quiet: assert property ($rose(handler_active) |-> !instr_ack)
		else $error("issue during entry");
	chk_mask_ack: assert property (mask_push || mask_pop |-> instr_ack)
		else $error("mask change without issue");
endmodule

bind thread_exception_entry_return thread_exc_chk chk_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .instr_valid, .instr_ack, .thread_ip, .handler_active, .mask_push, .mask_pop);

//--- bench/wb_return_model.sv
// holds a model of the handler side returning writebacks late
// assumes acks and instructions from the exception unit on pclk
module wb_return_model #(
	parameter int dly = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic instr_ack,
	input wire thread_exc_pkg::instr_t instr,
	output thread_exc_pkg::writeback_t wb
);
	timeunit 1ns;
	timeprecision 1ns;
	import thread_exc_pkg::*;
	writeback_t pipe [dly];
	// every accepted instruction retires dly cycles after its ack, several may be in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < dly; k++) begin
				pipe[k] <= '0;
			end
		end else begin
			pipe[0].valid <= instr_ack;
			pipe[0].dst <= instr.dst;
			pipe[0].keep_dependency_option <= instr.keep_dependency_option;
			for (int k = 1; k < dly; k++) begin
				pipe[k] <= pipe[k-1];
			end
		end
	end
	// an idle return path shows the inverted index, so a stray use of it is caught
	always_comb begin
		wb = pipe[dly-1];
		if (!pipe[dly-1].valid) begin
			wb.dst = ~pipe[dly-1].dst;
		end
	end
endmodule

//--- bench/thread_exception_entry_return_tb.sv
// holds the self-checking bench of the thread exception unit
// assumes the unit, its package and the writeback model
module thread_exception_entry_return_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import thread_exc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, pready, pslverr;
	logic instr_ack, handler_active, mask_push, mask_pop, e;
	logic [1:0] p;
	logic [7:0] paddr = 8'h00, exc_raise = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, thread_ip, q;
	instr_t instr = '0;
	writeback_t wb;
	int errors = 0, checks = 0, n, i;
	always #25 pclk = ~pclk;
	thread_exception_entry_return #(.hw_thread_index(8'h03), .exec_unit_index(8'h05)) dut_u (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exc_raise, .instr_valid,
		.instr, .instr_ack, .thread_ip, .handler_active, .mask_push, .mask_pop, .wb);
	wb_return_model #(.dly(6)) far_u (.pclk, .presetn, .instr_ack, .instr, .wb);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_of_test;
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// apb transfer, entered just after a rising edge; ready and data taken at the same rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin errors++; end_of_test(); end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// issue one instruction, holding it until the ack
	task automatic issue(input logic [6:0] d, input logic [6:0] s, input logic k, input logic c);
		instr <= '{d, s, k, 1'b0, c, c};
		instr_valid <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (instr_ack !== 1'b1 && n < 40);
		if (n >= 40) begin errors++; end_of_test(); end
		p = {mask_push, mask_pop};
		instr_valid <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic raise;
		exc_raise <= 8'h01;
		@(posedge pclk);
		exc_raise <= 8'h00;
		repeat (6) @(posedge pclk);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h1C, 32'h0000_0503);
		rd(8'h20, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(8'h0C, 32'h0000_1237);
		wr(8'h10, 32'h0000_ABCD);
		rd(8'h10, 32'h0000_ABCD);
		wr(8'h04, 32'h0000_0001);
		issue(7'h01, 7'h02, 1'b0, 1'b0);
		chk(thread_ip, 32'h10);
		raise();
		chk({31'h0, handler_active}, 32'h1);
		chk(thread_ip, 32'h1230);
		rd(8'h08, 32'h10);
		wr(8'h18, 32'h0000_00FE);
		rd(8'h18, 32'h0000_00FE);
		rd(8'h00, 32'h1);
		raise();
		chk(thread_ip, 32'h1230);
		issue(7'h03, 7'h04, 1'b0, 1'b0);
		chk(thread_ip, 32'h1240);
		rd(8'h08, 32'h10);
		rd(8'h04, 32'h101);
		wr(8'h00, 32'h0);
		repeat (6) @(posedge pclk);
		chk({31'h0, handler_active}, 32'h1);
		chk(thread_ip, 32'h1230);
		wr(8'h04, 32'h0000_0001);
		wr(8'h00, 32'h0);
		repeat (6) @(posedge pclk);
		chk({31'h0, handler_active}, 32'h0);
		chk(thread_ip, 32'h10);
		wr(8'h00, 32'h2);
		issue(7'h07, 7'h08, 1'b0, 1'b1);
		chk({30'h0, p}, 32'h0);
		wr(8'h00, 32'h0);
		issue(7'h07, 7'h08, 1'b0, 1'b1);
		chk({30'h0, p}, 32'h3);
		issue(7'h06, 7'h09, 1'b0, 1'b0);
		issue(7'h0A, 7'h06, 1'b0, 1'b0);
		chk({31'h0, n > 4}, 32'h1);
		issue(7'h05, 7'h0B, 1'b1, 1'b0);
		instr <= '{7'h0C, 7'h05, 1'b0, 1'b0, 1'b0, 1'b0};
		instr_valid <= 1'b1;
		n = 0;
		repeat (30) begin @(negedge pclk); if (instr_ack === 1'b1) n++; end
		chk(n, 32'h0);
		end_of_test();
	end
endmodule
